// ---- src/pclo_consts.svh ----
// Constants for the current-limit and output-override stage: register offsets,
// field positions, write masks and timing. Included by the package and the design file.
`ifndef PCLO_CONSTS_SVH
`define PCLO_CONSTS_SVH

// ----------------------------------------
// Register offsets (word addresses on the plain register port)
// ----------------------------------------
`define PCLO_ADDR_W          4
`define PCLO_OFF_FLTLIM      4'h0
`define PCLO_OFF_GENCTL      4'h1
`define PCLO_OFF_OUTCTL      4'h2
`define PCLO_OFF_MODCTL      4'h3
`define PCLO_OFF_STATUS      4'h4

// ----------------------------------------
// Fault/limit control register fields
// ----------------------------------------
`define PCLO_FL_LIMIT_SOURCE_SELECT_LSB    0
`define PCLO_FL_LIMIT_POLARITY        4
`define PCLO_FL_LIMIT_MODE_SELECT        5
`define PCLO_FL_FAULT_SOURCE_SELECT_LSB   8
`define PCLO_FL_FLTPOL       12
`define PCLO_FL_FLTEN        13
`define PCLO_FL_MASK         16'h3f3f

// ----------------------------------------
// Generator control register fields
// ----------------------------------------
`define PCLO_GC_LIMIT_IRQ_ENABLE        0
`define PCLO_GC_FLTIEN       1
`define PCLO_GC_IUE          2
`define PCLO_GC_ITB          3
`define PCLO_GC_EXTERNAL_RESET_SELECT_LSB    4
`define PCLO_GC_MASK         16'h003f
`define PCLO_EXTERNAL_RESET_SELECT_CURRENT   2'h1

// ----------------------------------------
// Output control register fields
// ----------------------------------------
`define PCLO_OC_HIGH_PIN_OWN_ENABLE         0
`define PCLO_OC_LOW_PIN_OWN_ENABLE         1
`define PCLO_OC_MANUAL_OVERRIDE_EN_HIGH       2
`define PCLO_OC_MANUAL_OVERRIDE_EN_LOW       3
`define PCLO_OC_MANUAL_OVERRIDE_DATA_LSB   4
`define PCLO_OC_LIMIT_OVERRIDE_DATA_LSB    6
`define PCLO_OC_FAULT_OVERRIDE_DATA_LSB   8
`define PCLO_OC_OVERRIDE_SYNC_ENABLE        10
`define PCLO_OC_HPOL         11
`define PCLO_OC_LPOL         12
`define PCLO_OC_MASK         16'h1fff

// ----------------------------------------
// Module control register fields
// ----------------------------------------
`define PCLO_MC_MODEN        0
`define PCLO_MC_TIMEBASE_RUN_ENABLE         1
`define PCLO_MC_IDLSTOP      2
`define PCLO_MC_MASK         16'h0007

// ----------------------------------------
// Status register fields (read; writing a one to bit 0/1 clears the flag)
// ----------------------------------------
`define PCLO_ST_LIMIT_STATUS_BIT       0
`define PCLO_ST_FLTSTAT      1

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCLO_DT_NS           10
`define PCLO_CLK_PERIOD_NS   5
`define PCLO_DT_CYCLES       ((`PCLO_DT_NS + `PCLO_CLK_PERIOD_NS - 1) / `PCLO_CLK_PERIOD_NS)
`define PCLO_LSB_TIME_BIT    3

`endif

// ---- src/pclo_pkg.sv ----
// Types shared by the current-limit and output-override stage.
// Assumes pclo_consts.svh sits beside it on the include path.
`include "pclo_consts.svh"

package pclo_pkg;
    typedef logic [15:0] pclo_word_t;

    // Register port request from the software side.
    typedef struct packed {
        logic [`PCLO_ADDR_W-1:0] addr;
        logic [15:0]             wdata;
        logic                    wr;
        logic                    rd;
    } pclo_req_t;

    // High and low pin drive with output enables.
    typedef struct packed {
        logic hi_out;
        logic lo_out;
        logic hi_oe;
        logic lo_oe;
    } pclo_pins_t;

    // Signals offered to the ADC trigger logic and the interrupt controller.
    typedef struct packed {
        logic limit_trig;
        logic fault_trig;
        logic limit_irq;
        logic wake_req;
    } pclo_evt_t;

    typedef enum logic [2:0] {
        PCLO_OWN_GEN   = 3'b001,
        PCLO_OWN_LIMIT = 3'b010,
        PCLO_OWN_FAULT = 3'b100
    } pclo_owner_t;
endpackage

// ---- src/pclo_override.sv ----
// Current-limit and output-override stage of one PWM generator.
// Assumes limit/fault pins and generator outputs are synchronous to clk.
`timescale 1ns/1ps
`include "pclo_consts.svh"

module pclo_override #(
    parameter int NPINS     = 12,
    parameter int NGEN      = 4,
    parameter int DT_CYCLES = `PCLO_DT_CYCLES
) (
    input  wire logic                    clk,            // 200 MHz clock.
    input  wire logic                    resetn,         // Asynchronous reset, active low.
    input  wire pclo_pkg::pclo_req_t     req,            // Register port request.
    output logic [15:0]                  rdata,          // Read data, cycle after read strobe.
    input  wire logic [NPINS-1:0]        fault_pins,     // Shared limit/fault pins.
    input  wire logic                    gen_high,       // Generator high output.
    input  wire logic                    gen_low,        // Generator low output.
    input  wire logic                    complementary,  // Complementary output mode.
    input  wire logic                    timebase_zero,  // Timebase count is zero.
    input  wire logic                    instr_cycle,    // Instruction cycle boundary strobe.
    input  wire logic                    sleep_mode,     // Device in Sleep.
    input  wire logic                    idle_mode,      // Device in Idle.
    input  wire logic [NGEN-2:0]         other_lim_irq,  // Limit requests of other generators.
    input  wire logic                    gpio_high,      // Port logic drive, high pin.
    input  wire logic                    gpio_low,       // Port logic drive, low pin.
    input  wire logic                    gpio_high_oe,   // Port logic enable, high pin.
    input  wire logic                    gpio_low_oe,    // Port logic enable, low pin.
    output pclo_pkg::pclo_pins_t         pins,           // Pin drive and enables.
    output pclo_pkg::pclo_evt_t          evt,            // Triggers, requests, wake.
    output logic                         timebase_reset, // Current Reset to timebase: limit active, PCLO_FL_LIMIT_MODE_SELECT clear, PCLO_GC_ITB set, current reset source selected, stage not stopped.
    output logic                         duty_immediate  // Immediate duty update enable.
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] fltlim_r, genctl_r, outctl_r, modctl_r;
    logic [15:0] outctl_pend_r;
    logic        pend_r;
    logic [1:0]  ovr_en_r, ovr_dat_r;
    logic        lim_flag_r, flt_flag_r;
    logic [15:0] rdata_r;

    logic [3:0] lim_sel, flt_sel;
    logic       lim_raw, flt_raw, lim_act, flt_act;
    logic       mod_en, stopped, ptrun;

    assign lim_sel = fltlim_r[`PCLO_FL_LIMIT_SOURCE_SELECT_LSB +: 4];
    assign flt_sel = fltlim_r[`PCLO_FL_FAULT_SOURCE_SELECT_LSB +: 4];
    // Unimplemented source codes read as a low input.
    assign lim_raw = (32'(lim_sel) < NPINS) ? fault_pins[lim_sel] : 1'b0;
    assign flt_raw = (32'(flt_sel) < NPINS) ? fault_pins[flt_sel] : 1'b0;
    assign lim_act = lim_raw ^ fltlim_r[`PCLO_FL_LIMIT_POLARITY];
    assign flt_act = flt_raw ^ fltlim_r[`PCLO_FL_FLTPOL];
    assign mod_en  = modctl_r[`PCLO_MC_MODEN];
    assign ptrun   = modctl_r[`PCLO_MC_TIMEBASE_RUN_ENABLE];
    assign stopped = sleep_mode | (idle_mode & modctl_r[`PCLO_MC_IDLSTOP]);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    logic wr_out;
    assign wr_out = req.wr && req.addr == `PCLO_OFF_OUTCTL;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fltlim_r <= 16'h0000;
            genctl_r <= 16'h0000;
            modctl_r <= 16'h0000;
        end else if (req.wr) begin
            if (req.addr == `PCLO_OFF_FLTLIM) fltlim_r <= req.wdata & `PCLO_FL_MASK;
            if (req.addr == `PCLO_OFF_GENCTL) genctl_r <= req.wdata & `PCLO_GC_MASK;
            if (req.addr == `PCLO_OFF_MODCTL) modctl_r <= req.wdata & `PCLO_MC_MASK;
        end
    end

    // With the timebase stopped, output control writes wait for the next
    // instruction cycle boundary; a running timebase takes them at once.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            outctl_r      <= 16'h0000;
            outctl_pend_r <= 16'h0000;
            pend_r        <= 1'b0;
        end else if (wr_out && ptrun) begin
            outctl_r <= req.wdata & `PCLO_OC_MASK;
            pend_r   <= 1'b0;
        end else if (wr_out) begin
            outctl_pend_r <= req.wdata & `PCLO_OC_MASK;
            pend_r        <= 1'b1;
        end else if (pend_r && instr_cycle) begin
            outctl_r <= outctl_pend_r;
            pend_r   <= 1'b0;
        end
    end

    // Manual override shadow: synchronised copies update only at timebase zero while the timebase runs.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovr_en_r  <= 2'h0;
            ovr_dat_r <= 2'h0;
        end else if (!outctl_r[`PCLO_OC_OVERRIDE_SYNC_ENABLE] || timebase_zero || !ptrun) begin
            ovr_en_r  <= {outctl_r[`PCLO_OC_MANUAL_OVERRIDE_EN_HIGH], outctl_r[`PCLO_OC_MANUAL_OVERRIDE_EN_LOW]};
            ovr_dat_r <= outctl_r[`PCLO_OC_MANUAL_OVERRIDE_DATA_LSB +: 2];
        end
    end

    // ----------------------------------------
    // Interrupt flags: set wins over the software clear
    // ----------------------------------------
    logic clr_lim, clr_flt;
    assign clr_lim = req.wr && req.addr == `PCLO_OFF_STATUS && req.wdata[`PCLO_ST_LIMIT_STATUS_BIT];
    assign clr_flt = req.wr && req.addr == `PCLO_OFF_STATUS && req.wdata[`PCLO_ST_FLTSTAT];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lim_flag_r <= 1'b0;
            flt_flag_r <= 1'b0;
        end else begin
            lim_flag_r <= (lim_act & genctl_r[`PCLO_GC_LIMIT_IRQ_ENABLE]) | (lim_flag_r & ~clr_lim
                          & genctl_r[`PCLO_GC_LIMIT_IRQ_ENABLE]);
            flt_flag_r <= (flt_act & genctl_r[`PCLO_GC_FLTIEN]) | (flt_flag_r & ~clr_flt
                          & genctl_r[`PCLO_GC_FLTIEN]);
        end
    end

    // ----------------------------------------
    // Override resolution
    // ----------------------------------------
    logic lim_ovr, flt_ovr;
    logic [1:0] pre, ovr_dat;
    logic [1:0] dly_q [DT_CYCLES];
    logic [1:0] dt_out, final_lvl, pol;
    pclo_pkg::pclo_owner_t owner;

    assign lim_ovr = genctl_r[`PCLO_GC_LIMIT_IRQ_ENABLE] & lim_act;
    assign flt_ovr = fltlim_r[`PCLO_FL_FLTEN] & flt_act;
    assign pol     = {outctl_r[`PCLO_OC_HPOL], outctl_r[`PCLO_OC_LPOL]};

    always_comb begin
        if (flt_ovr) begin
            owner   = pclo_pkg::PCLO_OWN_FAULT;
            ovr_dat = outctl_r[`PCLO_OC_FAULT_OVERRIDE_DATA_LSB +: 2];
        end else if (lim_ovr) begin
            owner   = pclo_pkg::PCLO_OWN_LIMIT;
            ovr_dat = outctl_r[`PCLO_OC_LIMIT_OVERRIDE_DATA_LSB +: 2];
        end else begin
            owner   = pclo_pkg::PCLO_OWN_GEN;
            ovr_dat = 2'h0;
        end
    end

    // Lowest priority first: generator, then manual override, then limit/fault.
    always_comb begin
        pre[1] = ovr_en_r[1] ? ovr_dat_r[1] : gen_high;
        pre[0] = ovr_en_r[0] ? ovr_dat_r[0] : gen_low;
        if (owner != pclo_pkg::PCLO_OWN_GEN) pre = ovr_dat;
        // In either mode the overridden levels still pass the dead-time
        // unit; in both modes only the asserting edge is delayed below.
        if (!complementary && owner == pclo_pkg::PCLO_OWN_GEN && ovr_en_r == 2'h0) pre = {gen_high, gen_low};
    end

    // Clocked dead-time line. Rising levels leave after DT_CYCLES; a falling
    // level is gated at the pin so shutdown never waits for this delay.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < DT_CYCLES; i++) dly_q[i] <= 2'h0;
        end else begin
            dly_q[0] <= pre;
            for (int i = 1; i < DT_CYCLES; i++) dly_q[i] <= dly_q[i-1];
        end
    end

    assign dt_out = (complementary ? dly_q[DT_CYCLES-1] & pre : pre & dly_q[DT_CYCLES-1]);

    // Override data also gates just ahead of the pin buffers.
    assign final_lvl = (owner != pclo_pkg::PCLO_OWN_GEN) ? (dt_out & ovr_dat) : dt_out;

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    always_comb begin
        if (!mod_en) begin
            pins.hi_out = gpio_high;
            pins.lo_out = gpio_low;
            pins.hi_oe  = gpio_high_oe;
            pins.lo_oe  = gpio_low_oe;
        end else begin
            pins.hi_out = final_lvl[1] ^ pol[1];
            pins.lo_out = final_lvl[0] ^ pol[0];
            pins.hi_oe  = outctl_r[`PCLO_OC_HIGH_PIN_OWN_ENABLE];
            pins.lo_oe  = outctl_r[`PCLO_OC_LOW_PIN_OWN_ENABLE];
        end
        if (!resetn) begin
            pins.hi_oe = 1'b0;
            pins.lo_oe = 1'b0;
        end
    end

    // ----------------------------------------
    // Events and mode outputs
    // ----------------------------------------
    assign evt.limit_trig = lim_act;
    assign evt.fault_trig = flt_act;
    assign evt.limit_irq  = lim_flag_r | (|other_lim_irq);
    // Wake works without a running clock: a pure gate on the selected pin.
    assign evt.wake_req   = stopped & mod_en & ~flt_raw;

    assign timebase_reset = ~fltlim_r[`PCLO_FL_LIMIT_MODE_SELECT] & genctl_r[`PCLO_GC_ITB]
                            & (genctl_r[`PCLO_GC_EXTERNAL_RESET_SELECT_LSB +: 2] == `PCLO_EXTERNAL_RESET_SELECT_CURRENT)
                            & lim_act & ~stopped;
    assign duty_immediate = genctl_r[`PCLO_GC_IUE];

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 16'h0000;
        end else if (req.rd) begin
            unique case (req.addr)
                `PCLO_OFF_FLTLIM: rdata_r <= fltlim_r;
                `PCLO_OFF_GENCTL: rdata_r <= genctl_r;
                `PCLO_OFF_OUTCTL: rdata_r <= outctl_r;
                `PCLO_OFF_MODCTL: rdata_r <= modctl_r;
                `PCLO_OFF_STATUS: rdata_r <= {14'h0000,
                    genctl_r[`PCLO_GC_FLTIEN] ? flt_flag_r : flt_act,
                    genctl_r[`PCLO_GC_LIMIT_IRQ_ENABLE] ? lim_flag_r : lim_act};
                default:          rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end
    assign rdata = rdata_r;
endmodule

// ---- tb/pclo_override_props.sv ----
// Checker for the current-limit and output-override stage.
// Assumes it is bound to pclo_override and sees only its ports.
`timescale 1ns/1ps

module pclo_override_props #(
    parameter int NPINS = 12,
    parameter int NGEN  = 4
) (
    input wire logic                 clk,            // Clock.
    input wire logic                 resetn,         // Reset, active low.
    input wire pclo_pkg::pclo_req_t  req,            // Register request.
    input wire logic [15:0]          rdata,          // Read data.
    input wire logic [NPINS-1:0]     fault_pins,     // Shared pins.
    input wire logic                 gen_high,       // Generator high.
    input wire logic                 gen_low,        // Generator low.
    input wire logic                 complementary,  // Complementary mode.
    input wire logic                 timebase_zero,  // Timebase at zero.
    input wire logic                 instr_cycle,    // Cycle boundary.
    input wire logic                 sleep_mode,     // Sleep.
    input wire logic                 idle_mode,      // Idle.
    input wire logic [NGEN-2:0]      other_lim_irq,  // Other requests.
    input wire logic                 gpio_high,      // Port drive high.
    input wire logic                 gpio_low,       // Port drive low.
    input wire logic                 gpio_high_oe,   // Port enable high.
    input wire logic                 gpio_low_oe,    // Port enable low.
    input wire pclo_pkg::pclo_pins_t pins,           // Pin drive.
    input wire pclo_pkg::pclo_evt_t  evt,            // Events.
    input wire logic                 timebase_reset, // Current Reset.
    input wire logic                 duty_immediate  // Immediate update.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_rdata_read_slot: assert property ((rdata != 16'h0000) |-> $past(req.rd))
        else $error("read data outside its slot");
    a_irq_or_other: assert property ((|other_lim_irq) |-> evt.limit_irq)
        else $error("other limit request not merged");
    a_wake_cause: assert property (evt.wake_req |-> (sleep_mode || idle_mode) && !(&fault_pins))
        else $error("wake without stop and low pin");
    a_tb_reset_cause: assert property (timebase_reset |-> evt.limit_trig)
        else $error("timebase reset without limit");
    a_duty_by_write: assert property ($changed(duty_immediate) |-> $past(req.wr) && $past(req.addr) == 4'h1)
        else $error("immediate update changed without write");
    a_trig_steady: assert property ($stable(fault_pins) && !$past(req.wr) |-> $stable(evt.limit_trig))
        else $error("limit trigger moved without cause");
    a_oe_change_cause: assert property ($changed(pins.hi_oe) |->
            $past(req.wr) || $past(instr_cycle) || $past(timebase_zero) || $changed(gpio_high_oe))
        else $error("high enable moved without cause");
    a_disabled_gpio: assert property ((req.wr && req.addr == 4'h3 && !req.wdata[0]) |=>
            (pins == {gpio_high, gpio_low, gpio_high_oe, gpio_low_oe}) until (req.wr && req.addr == 4'h3))
        else $error("disabled module not handing pins to port");
endmodule

// ---- tb/pclo_cmp_model.sv ----
// External comparators feeding the shared limit/fault pins.
// Assumes the bench picks which pins carry the limit and fault levels.
`timescale 1ns/1ps

module pclo_cmp_model (
    input  wire logic        clk,     // Clock.
    input  wire logic [3:0]  lim_sel, // Pin carrying the limit level.
    input  wire logic        lim_raw, // Raw limit level.
    input  wire logic [3:0]  flt_sel, // Pin carrying the fault level.
    input  wire logic        flt_raw, // Raw fault level.
    output logic      [11:0] pads     // Shared pins.
);
    // Unused pins toggle at random so a wrong source select shows up.
    always_ff @(posedge clk) begin
        logic [11:0] p;
        p = 12'($urandom);
        p[lim_sel] = lim_raw;
        p[flt_sel] = flt_raw;
        pads <= p;
    end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for pclo_override.
// Assumes the package, the checker and the comparator model are compiled first.
`timescale 1ns/1ps

module tb;
    logic clk, resetn, gen_high, gen_low, timebase_zero, instr_cycle, sleep_mode, idle_mode;
    logic gpio_high, gpio_low, gpio_high_oe, gpio_low_oe, lim_raw, flt_raw, timebase_reset, duty_immediate;
    logic                 complementary;
    logic [3:0]           lim_sel, flt_sel;
    logic [2:0]           other_lim_irq;
    logic [11:0]          fault_pins;
    logic [15:0]          rdata;
    pclo_pkg::pclo_req_t  req;
    pclo_pkg::pclo_pins_t pins;
    pclo_pkg::pclo_evt_t  evt;
    int                   num_errors = 0;
    int                   samples_checked = 0;

    pclo_override u_pclo_override (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
        .fault_pins(fault_pins), .gen_high(gen_high), .gen_low(gen_low), .complementary(complementary),
        .timebase_zero(timebase_zero), .instr_cycle(instr_cycle), .sleep_mode(sleep_mode),
        .idle_mode(idle_mode), .other_lim_irq(other_lim_irq), .gpio_high(gpio_high), .gpio_low(gpio_low),
        .gpio_high_oe(gpio_high_oe), .gpio_low_oe(gpio_low_oe), .pins(pins), .evt(evt),
        .timebase_reset(timebase_reset), .duty_immediate(duty_immediate));
    pclo_cmp_model u_pclo_cmp_model (.clk(clk), .lim_sel(lim_sel), .lim_raw(lim_raw),
        .flt_sel(flt_sel), .flt_raw(flt_raw), .pads(fault_pins));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------
    // Bus, compare and expectation helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [15:0] outs();
        return 16'({pins.hi_out, pins.lo_out});
    endfunction
    // Priority from generator up through manual, limit and fault overrides.
    function automatic logic [15:0] exp_pins(input logic [15:0] oc, input logic lim, input logic flt,
                                             input logic [1:0] g);
        logic [1:0] v;
        v = g;
        if (oc[2]) v[1] = oc[5];
        if (oc[3]) v[0] = oc[4];
        if (lim) v = oc[7:6];
        if (flt) v = oc[9:8];
        return 16'(v);
    endfunction
    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] v;
        logic [15:0] oc;
        logic        pol;
        void'($urandom(79));
        {req, gen_high, gen_low, timebase_zero, instr_cycle, sleep_mode, idle_mode, other_lim_irq} = '0;
        {gpio_high, gpio_low, gpio_high_oe, gpio_low_oe, lim_raw, flt_raw, lim_sel} = '0;
        flt_sel = 4'h1;
        complementary = 1'b0;
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        chk(16'({pins.hi_oe, pins.lo_oe}), 16'h0000);
        resetn <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            rd(4'(a), v);
            chk(v, 16'h0000);
        end
        rd(4'h7, v);
        chk(v, 16'h0000);
        wr(4'h1, 16'hffff);
        rd(4'h1, v);
        chk(v, 16'h003f);
        chk(16'(duty_immediate), 16'h0001);
        wr(4'h1, 16'h0000);
        wr(4'h3, 16'h0003);
        repeat (40) begin
            oc = 16'h0003 | 16'(($urandom & 15) << 2);
            wr(4'h2, oc);
            {gen_high, gen_low} <= 2'($urandom);
            complementary <= 1'($urandom);
            cyc(4);
            chk(outs(), exp_pins(oc, 1'b0, 1'b0, {gen_high, gen_low}));
            chk(16'({pins.hi_oe, pins.lo_oe}), 16'h0003);
        end
        wr(4'h2, 16'h0000);
        cyc(3);
        chk(16'({pins.hi_oe, pins.lo_oe}), 16'h0000);
        for (int i = 0; i < 12; i++) begin
            pol = 1'($urandom);
            oc = 16'h0003 | 16'(($urandom & 15) << 6);
            lim_sel <= 4'(i);
            flt_sel <= 4'((i + 5) % 12);
            lim_raw <= ~pol;
            flt_raw <= 1'($urandom);
            wr(4'h0, 16'(i) | (16'(pol) << 4) | (16'((i + 5) % 12) << 8) | 16'h2000);
            wr(4'h1, 16'h0001);
            wr(4'h2, oc);
            cyc(4);
            chk(16'(evt.limit_trig), 16'h0001);
            chk(16'(evt.fault_trig), 16'(flt_raw));
            chk(outs(), exp_pins(oc, 1'b1, flt_raw, {gen_high, gen_low}));
            rd(4'h4, v);
            chk(v & 16'h0001, 16'h0001);
            lim_raw <= pol;
            flt_raw <= 1'b0;
            cyc(4);
            chk(outs(), exp_pins(oc, 1'b0, 1'b0, {gen_high, gen_low}));
            wr(4'h1, 16'h0000);
            rd(4'h4, v);
            chk(v & 16'h0001, 16'h0000);
        end
        lim_sel <= 4'h0;
        lim_raw <= 1'b1;
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0018);
        cyc(3);
        chk(16'(timebase_reset), 16'h0001);
        wr(4'h0, 16'h0020);
        cyc(1);
        chk(16'(timebase_reset), 16'h0000);
        other_lim_irq <= 3'($urandom) | 3'h1;
        cyc(2);
        chk(16'(evt.limit_irq), 16'h0001);
        other_lim_irq <= 3'h0;
        cyc(2);
        chk(16'(evt.limit_irq), 16'h0000);
        flt_sel <= 4'h3;
        wr(4'h0, 16'h0300);
        sleep_mode <= 1'b1;
        cyc(3);
        chk(16'(evt.wake_req), 16'h0001);
        sleep_mode <= 1'b0;
        idle_mode <= 1'b1;
        wr(4'h3, 16'h0007);
        cyc(2);
        chk(16'(evt.wake_req), 16'h0001);
        wr(4'h3, 16'h0003);
        cyc(2);
        chk(16'(evt.wake_req), 16'h0000);
        idle_mode <= 1'b0;
        wr(4'h3, 16'h0001);
        {gen_high, gen_low} <= 2'b11;
        wr(4'h2, 16'h000f);
        cyc(4);
        chk(outs(), 16'h0003);
        instr_cycle <= 1'b1;
        cyc(1);
        instr_cycle <= 1'b0;
        cyc(3);
        chk(outs(), 16'h0000);
        wr(4'h3, 16'h0003);
        {gen_high, gen_low} <= 2'b00;
        wr(4'h2, 16'h043f);
        cyc(4);
        chk(outs(), 16'h0000);
        timebase_zero <= 1'b1;
        cyc(1);
        timebase_zero <= 1'b0;
        cyc(1);
        chk(outs(), 16'h0000);
        cyc(3);
        chk(outs(), 16'h0003);
        resetn <= 1'b0;
        cyc(2);
        chk(16'({pins.hi_oe, pins.lo_oe}), 16'h0000);
        resetn <= 1'b1;
        wr(4'h3, 16'h0000);
        repeat (8) begin
            {gpio_high, gpio_low, gpio_high_oe, gpio_low_oe} <= 4'($urandom);
            cyc(2);
            chk(16'(pins), 16'({gpio_high, gpio_low, gpio_high_oe, gpio_low_oe}));
        end
        print_verdict();
    end
endmodule

bind pclo_override pclo_override_props #(.NPINS(NPINS), .NGEN(NGEN)) u_pclo_override_props (
    .clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .fault_pins(fault_pins), .gen_high(gen_high),
    .gen_low(gen_low), .complementary(complementary), .timebase_zero(timebase_zero),
    .instr_cycle(instr_cycle), .sleep_mode(sleep_mode), .idle_mode(idle_mode), .other_lim_irq(other_lim_irq),
    .gpio_high(gpio_high), .gpio_low(gpio_low), .gpio_high_oe(gpio_high_oe), .gpio_low_oe(gpio_low_oe),
    .pins(pins), .evt(evt), .timebase_reset(timebase_reset), .duty_immediate(duty_immediate));
